//--- logic/homing_regs.svh
// Purpose: Named constants for the homing sequencer
// Assumes: Included by bare name from the sequencer
// Notes: Method codes are those written to the homing method object
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH

// ==========================================================
// Homing method object address
`define HOME_OBJ_INDEX 16'h6098
`define HOME_OBJ_SUB 8'h00

// ==========================================================
// Method codes
`define HOME_M27 8'h1b
`define HOME_M28 8'h1c
`define HOME_M29 8'h1d
`define HOME_M30 8'h1e
`define HOME_M31 8'h1f
`define HOME_M32 8'h20
`define HOME_M33 8'h21
`define HOME_M34 8'h22

// ==========================================================
// Reset values and widths
`define HOME_METHOD_RST 8'h00
`define HOME_STEP_RST 2'h0
`define HOME_STEP_ONE 2'h1
`define HOME_CNT_W 16

`endif

//--- logic/homing_pkg.sv
// Purpose: Types shared by the homing sequencer files
// Assumes: Constants live in homing_regs.svh
// Notes: Phase table entries are packed structs
package homing_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEARCH = 3'b001,
    ST_DECEL = 3'b010,
    ST_DONE = 3'b011,
    ST_FAULT = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    BR_OFF = 2'b00,
    BR_ON = 2'b01,
    BR_LIMIT = 2'b10
  } branch_t;

  typedef enum logic [1:0] {
    WAIT_RISE = 2'b00,
    WAIT_FALL = 2'b01,
    WAIT_INDEX = 2'b10
  } wait_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic fwd;
    logic high;
    wait_t kind;
  } phase_t;

endpackage : homing_pkg

//--- logic/edge_sync.sv
// Purpose: Two-flop synchroniser with edge detection for one pin
// Assumes: Pin is asynchronous to ref_clk
// Notes: Level and edge outputs are registered
`timescale 1ns/1ps
module edge_sync
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pin
  input wire logic pin,
  // Synchronised outputs
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
    end
  end

  // ==========================================================
  // Edge detection
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      level <= sync_reg;
      rise <= sync_reg & ~level;
      fall <= ~sync_reg & level;
    end
  end

endmodule : edge_sync

//--- logic/homing_sequencer.sv
// Purpose: Homing sequencer for return methods 27 to 34
// Assumes: Method object writes and start come from logic on ref_clk
// Notes: Speed is commanded as run, direction and high/low select
//
// Summary of operation
// RULE1: Method taken from object 6098 sub 00h
// RULE2: Home switch level at start picks branch
// RULE3: M27 off: reverse high, forward low fall
// RULE4: M27 on: forward low, stop on fall
// RULE5: M27 limit: forward high fall, reverse low rise
// RULE6: M28 off: rev high, fwd low, rev low
// RULE7: M28 on: forward low fall, reverse low rise
// RULE8: M28 limit: forward high fall, reverse low rise
// RULE9: M29: reverse high fall, forward low rise
// RULE10: M29 limit: fwd high, rev low, fwd low
// RULE11: M30: rev high fall, fwd rise, rev fall
// RULE12: M30 limit: forward high rise, reverse low fall
// RULE13: Codes 31 and 32 reserved, no sequence
// RULE14: M33: reverse until first index pulse
// RULE15: M34: forward until first index pulse
// RULE16: Stop fully before reversing; edges after reversal
// RULE17: Done flag on final edge, hold zero speed
`timescale 1ns/1ps
`include "homing_regs.svh"
module homing_sequencer
  import homing_pkg::*;
#(
  parameter int DECEL_CYCLES = 16
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Homing method object write
  input wire logic obj_wr_en,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [7:0] obj_data,
  // Control
  input wire logic start,
  // Sensors
  input wire logic home_sw,
  input wire logic rev_limit,
  input wire logic index_pulse,
  // Motion command
  output logic run,
  output logic dir_fwd,
  output logic speed_high,
  output logic stop_cmd,
  // Status
  output logic homing_done,
  output logic method_error,
  output logic [7:0] method_code
);

  localparam logic [`HOME_CNT_W-1:0] DECEL_LOAD = `HOME_CNT_W'(DECEL_CYCLES - 1);

  state_t state_reg, state_next;
  branch_t branch_reg, branch_next;
  logic [1:0] step_reg, step_next;
  logic [7:0] method_reg, run_method_reg, mth;
  logic [`HOME_CNT_W-1:0] cnt_reg;
  logic run_reg, fwd_reg, high_reg, done_reg, err_reg;
  logic home_lvl, home_rise, home_fall, lim_lvl, idx_rise;
  logic method_ok, limit_hit, edge_hit;
  phase_t cur, nxt;

  // ==========================================================
  // Pin synchronisers
  edge_sync u_home (.ref_clk(ref_clk), .rst(rst), .pin(home_sw),
    .level(home_lvl), .rise(home_rise), .fall(home_fall));
  edge_sync u_lim (.ref_clk(ref_clk), .rst(rst), .pin(rev_limit),
    .level(lim_lvl), .rise(), .fall());
  edge_sync u_idx (.ref_clk(ref_clk), .rst(rst), .pin(index_pulse),
    .level(), .rise(idx_rise), .fall());

  // ==========================================================
  // Phase table
  function automatic phase_t ph(input logic last, input logic fwd, input logic high,
    input wait_t kind);
    ph = '{valid: 1'b1, last: last, fwd: fwd, high: high, kind: kind};
  endfunction : ph

  function automatic phase_t lookup(input logic [7:0] m, input branch_t b,
    input logic [1:0] s);
    lookup = '0;
    unique case (m)
      `HOME_M27:
        if (b == BR_LIMIT)
          lookup = (s == 2'd0) ? ph(1'b0, 1'b1, 1'b1, WAIT_FALL) : ph(1'b1, 1'b0, 1'b0, WAIT_RISE); // RULE5
        else if (b == BR_ON)
          lookup = ph(1'b1, 1'b1, 1'b0, WAIT_FALL); // RULE4
        else
          lookup = (s == 2'd0) ? ph(1'b0, 1'b0, 1'b1, WAIT_RISE) : ph(1'b1, 1'b1, 1'b0, WAIT_FALL); // RULE3
      `HOME_M28:
        if (b == BR_LIMIT || b == BR_ON)
          lookup = (s == 2'd0) ? ph(1'b0, 1'b1, b == BR_LIMIT, WAIT_FALL) // RULE7 RULE8
                               : ph(1'b1, 1'b0, 1'b0, WAIT_RISE);
        else if (s == 2'd0)
          lookup = ph(1'b0, 1'b0, 1'b1, WAIT_RISE); // RULE6
        else if (s == 2'd1)
          lookup = ph(1'b0, 1'b1, 1'b0, WAIT_FALL); // RULE6
        else
          lookup = ph(1'b1, 1'b0, 1'b0, WAIT_RISE); // RULE6
      `HOME_M29:
        if (b == BR_LIMIT)
        begin
          if (s == 2'd0)
            lookup = ph(1'b0, 1'b1, 1'b1, WAIT_RISE); // RULE10
          else if (s == 2'd1)
            lookup = ph(1'b0, 1'b0, 1'b0, WAIT_FALL); // RULE10
          else
            lookup = ph(1'b1, 1'b1, 1'b0, WAIT_RISE); // RULE10
        end
        else
          lookup = (s == 2'd0) ? ph(1'b0, 1'b0, 1'b1, WAIT_FALL) : ph(1'b1, 1'b1, 1'b0, WAIT_RISE); // RULE9
      `HOME_M30:
        if (b == BR_LIMIT)
          lookup = (s == 2'd0) ? ph(1'b0, 1'b1, 1'b1, WAIT_RISE) : ph(1'b1, 1'b0, 1'b0, WAIT_FALL); // RULE12
        else if (s == 2'd0)
          lookup = ph(1'b0, 1'b0, 1'b1, WAIT_FALL); // RULE11
        else if (s == 2'd1)
          lookup = ph(1'b0, 1'b1, 1'b0, WAIT_RISE); // RULE11
        else
          lookup = ph(1'b1, 1'b0, 1'b0, WAIT_FALL); // RULE11
      `HOME_M33: lookup = ph(1'b1, 1'b0, 1'b0, WAIT_INDEX); // RULE14
      `HOME_M34: lookup = ph(1'b1, 1'b1, 1'b0, WAIT_INDEX); // RULE15
      default: lookup = '0; // RULE13
    endcase
  endfunction : lookup

  // ==========================================================
  // Method object
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      method_reg <= `HOME_METHOD_RST;
    else if (obj_wr_en && obj_index == `HOME_OBJ_INDEX && obj_sub == `HOME_OBJ_SUB)
      method_reg <= obj_data; // RULE1
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      run_method_reg <= `HOME_METHOD_RST;
    else if (state_reg != ST_SEARCH && state_reg != ST_DECEL && start)
      run_method_reg <= method_reg;
  end

  assign mth = (state_reg == ST_SEARCH || state_reg == ST_DECEL) ? run_method_reg : method_reg;
  assign method_ok = lookup(method_reg, BR_OFF, `HOME_STEP_RST).valid; // RULE13
  assign cur = lookup(mth, branch_reg, step_reg);
  assign nxt = lookup(mth, branch_next, step_next);
  // Reverse limit only diverts the initial high speed reverse search
  assign limit_hit = lim_lvl && branch_reg != BR_LIMIT && step_reg == `HOME_STEP_RST &&
    !cur.fwd && cur.high && mth != `HOME_M33; // RULE5 RULE8 RULE10 RULE12
  assign edge_hit = (cur.kind == WAIT_RISE && home_rise) ||
    (cur.kind == WAIT_FALL && home_fall) || (cur.kind == WAIT_INDEX && idx_rise);

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    branch_next = branch_reg;
    step_next = step_reg;
    unique case (state_reg)
      ST_IDLE, ST_DONE, ST_FAULT:
        if (start)
        begin
          step_next = `HOME_STEP_RST;
          branch_next = home_lvl ? BR_ON : BR_OFF; // RULE2
          state_next = method_ok ? ST_SEARCH : ST_FAULT; // RULE13
        end
      ST_SEARCH:
        if (limit_hit)
        begin
          branch_next = BR_LIMIT;
          step_next = `HOME_STEP_RST;
          state_next = ST_DECEL; // RULE16
        end
        else if (edge_hit)
        begin
          if (cur.last)
            state_next = ST_DONE; // RULE17
          else
          begin
            step_next = step_reg + `HOME_STEP_ONE;
            state_next = ST_DECEL; // RULE16
          end
        end
      ST_DECEL:
        if (cnt_reg == '0)
          state_next = ST_SEARCH;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      branch_reg <= BR_OFF;
      step_reg <= `HOME_STEP_RST;
    end
    else
    begin
      state_reg <= state_next;
      branch_reg <= branch_next;
      step_reg <= step_next;
    end
  end

  // Deceleration dwell at zero speed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (state_reg != ST_DECEL)
      cnt_reg <= DECEL_LOAD;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - `HOME_CNT_W'(1);
  end

  // ==========================================================
  // Motion command
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_reg <= 1'b0;
      fwd_reg <= 1'b0;
      high_reg <= 1'b0;
    end
    else
    begin
      run_reg <= state_next == ST_SEARCH; // RULE16 RULE17
      if (state_next == ST_SEARCH)
      begin
        fwd_reg <= nxt.fwd;
        high_reg <= nxt.high;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      done_reg <= state_next == ST_DONE; // RULE17
      err_reg <= state_next == ST_FAULT;
    end
  end

  assign run = run_reg;
  assign dir_fwd = fwd_reg;
  assign speed_high = high_reg;
  assign stop_cmd = ~run_reg;
  assign homing_done = done_reg;
  assign method_error = err_reg;
  assign method_code = method_reg;

  // ==========================================================
  // Checks
  AST_OBJ_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    obj_wr_en && obj_index == `HOME_OBJ_INDEX && obj_sub == `HOME_OBJ_SUB
    |=> method_reg == $past(obj_data))
    else $error("method object write not taken");

  AST_BRANCH_ON: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    state_reg != ST_SEARCH && state_reg != ST_DECEL && start && method_reg == `HOME_M27 &&
    home_lvl
    |=> branch_reg == BR_ON ##1 run && dir_fwd && !speed_high)
    else $error("switch-on branch not chosen");

  AST_M27_OFF: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    state_reg != ST_SEARCH && state_reg != ST_DECEL && start && method_reg == `HOME_M27 &&
    !home_lvl
    |=> ##1 run && !dir_fwd && speed_high)
    else $error("method 27 search not reverse high");

  AST_LIMIT: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    state_reg == ST_SEARCH && limit_hit |=> state_reg == ST_DECEL && branch_reg == BR_LIMIT)
    else $error("reverse limit not handled");

  AST_RESERVED: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    state_reg != ST_SEARCH && state_reg != ST_DECEL && start &&
    (method_reg == `HOME_M31 || method_reg == `HOME_M32)
    |=> ##1 method_error && !run)
    else $error("reserved method ran");

  AST_INDEX: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    state_reg == ST_SEARCH && run_method_reg == `HOME_M33 && idx_rise
    |=> ##1 homing_done && !run)
    else $error("index pulse did not end homing");

  AST_REVERSE: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    $changed(fwd_reg) |-> !$past(run_reg))
    else $error("direction changed while moving");

  AST_DECEL_END: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    $rose(state_reg == ST_DECEL) |-> !run [*2])
    else $error("speed not zero in deceleration");

  AST_DONE_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
    homing_done && !start |=> homing_done && !run)
    else $error("motor moved after homing done");

endmodule : homing_sequencer

//--- sim/motion_model.sv
// Purpose: Behavioural axis with home switch, reverse limit and index pin
// Assumes: High speed moves 4 counts a cycle, low speed 1
// Notes: Switch pins follow position, so they hold still when stopped
`timescale 1ns/1ps
module motion_model
#(
  parameter int HOME_LO = 100,
  parameter int HOME_HI = 199,
  parameter int LIMIT_POS = 0,
  parameter int INDEX_PITCH = 64
)
(
  // Clock
  input wire logic ref_clk,
  // Motion command
  input wire logic run,
  input wire logic dir_fwd,
  input wire logic speed_high,
  // Sensor pins
  output logic home_sw,
  output logic rev_limit,
  output logic index_pulse
);
  // ==========================================================
  // Axis position
  int pos = 400;

  always @(posedge ref_clk)
  begin
    if (run)
      pos <= dir_fwd ? pos + (speed_high ? 4 : 1) : pos - (speed_high ? 4 : 1);
  end

  // ==========================================================
  // Pins
  assign home_sw = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign rev_limit = pos <= LIMIT_POS;
  assign index_pulse = (pos % INDEX_PITCH) == 0;
endmodule : motion_model

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the homing sequencer
// Assumes: Motion model drives switch, limit and index pins
// Notes: Each move start is logged as {dir_fwd, speed_high}
`timescale 1ns/1ps
module tb_top;
  localparam int DECEL = 4;
  localparam logic [1:0] RL = 2'b00;
  localparam logic [1:0] RH = 2'b01;
  localparam logic [1:0] FL = 2'b10;
  localparam logic [1:0] FH = 2'b11;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic obj_wr_en = 1'b0;
  logic [15:0] obj_index = 16'h0000;
  logic [7:0] obj_sub = 8'h00;
  logic [7:0] obj_data = 8'h00;
  logic start = 1'b0;
  logic home_sw, rev_limit, index_pulse;
  logic run, dir_fwd, speed_high, stop_cmd, homing_done, method_error;
  logic [7:0] method_code;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [1:0] ph_q [$];
  logic [1:0] last_ph = 2'b00;
  logic run_d = 1'b0;
  int gap = 0;
  int min_gap = 1000;

  always #12.5 ref_clk = ~ref_clk;

  homing_sequencer #(.DECEL_CYCLES(DECEL)) uut (.ref_clk(ref_clk), .rst(rst),
    .obj_wr_en(obj_wr_en), .obj_index(obj_index), .obj_sub(obj_sub), .obj_data(obj_data),
    .start(start), .home_sw(home_sw), .rev_limit(rev_limit), .index_pulse(index_pulse),
    .run(run), .dir_fwd(dir_fwd), .speed_high(speed_high), .stop_cmd(stop_cmd),
    .homing_done(homing_done), .method_error(method_error), .method_code(method_code));

  motion_model motion (.ref_clk(ref_clk), .run(run), .dir_fwd(dir_fwd),
    .speed_high(speed_high), .home_sw(home_sw), .rev_limit(rev_limit),
    .index_pulse(index_pulse));

  // ==========================================================
  // Move logger: a new entry at every move start or on-the-fly change
  always @(posedge ref_clk)
  begin
    if (run === 1'b1 && (run_d !== 1'b1 || {dir_fwd, speed_high} !== last_ph))
    begin
      if (ph_q.size() > 0 && gap < min_gap)
        min_gap = gap;
      ph_q.push_back({dir_fwd, speed_high});
    end
    gap = (run === 1'b1) ? 0 : gap + 1;
    run_d = run;
    last_ph = {dir_fwd, speed_high};
  end

  // ==========================================================
  // Helpers
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cycles

  task automatic write_obj(input logic [15:0] idx, input logic [7:0] sub,
    input logic [7:0] data);
    obj_index = idx;
    obj_sub = sub;
    obj_data = data;
    obj_wr_en = 1'b1;
    cycles(1);
    obj_wr_en = 1'b0;
  endtask : write_obj

  task automatic pulse_start;
    start = 1'b1;
    cycles(1);
    start = 1'b0;
  endtask : pulse_start

  task automatic wait_done;
    int i;
    for (i = 0; i < 5000 && homing_done !== 1'b1; i++)
      cycles(1);
    if (homing_done !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: homing never completed", $time);
      stop_test();
    end
  endtask : wait_done

  // Expected moves are packed first move in the low bits
  task automatic run_case(input string name, input logic [7:0] code, input int pos0,
    input logic [7:0] seq, input int n, input bit restart);
    int k;
    motion.pos = pos0;
    write_obj(16'h6098, 8'h00, code);
    cycles(6);
    check(method_code, code, "method code");
    ph_q.delete();
    min_gap = 1000;
    pulse_start();
    if (restart)
    begin
      cycles(20);
      pulse_start();
    end
    wait_done();
    check(16'(ph_q.size()), 16'(n), "move count");
    for (k = 0; k < n && k < ph_q.size(); k++)
      check(ph_q[k], seq[2*k +: 2], "move kind");
    check(min_gap >= DECEL, 1'b1, "zero speed dwell");
    cycles(10);
    check({run, stop_cmd, homing_done}, 3'b011, "held after done");
    $display("test %s done", name);
  endtask : run_case

  // ==========================================================
  // Scenarios
  task automatic test_m27;
    run_case("m27 off", 8'h1b, 400, {FL, RH}, 2, 1'b0);
    run_case("m27 on", 8'h1b, 150, {FL}, 1, 1'b0);
    run_case("m27 limit", 8'h1b, 50, {RL, FH, RH}, 3, 1'b0);
  endtask : test_m27

  task automatic test_m28;
    run_case("m28 off", 8'h1c, 400, {RL, FL, RH}, 3, 1'b1);
    run_case("m28 on", 8'h1c, 150, {RL, FL}, 2, 1'b0);
    run_case("m28 limit", 8'h1c, 50, {RL, FH, RH}, 3, 1'b0);
  endtask : test_m28

  task automatic test_m29;
    run_case("m29 off", 8'h1d, 400, {FL, RH}, 2, 1'b0);
    run_case("m29 on", 8'h1d, 150, {FL, RH}, 2, 1'b0);
    run_case("m29 limit", 8'h1d, 50, {FL, RL, FH, RH}, 4, 1'b0);
  endtask : test_m29

  task automatic test_m30;
    run_case("m30 off", 8'h1e, 400, {RL, FL, RH}, 3, 1'b0);
    run_case("m30 on", 8'h1e, 150, {RL, FL, RH}, 3, 1'b0);
    run_case("m30 limit", 8'h1e, 50, {RL, FH, RH}, 3, 1'b0);
  endtask : test_m30

  task automatic test_index;
    run_case("m33", 8'h21, 400, {RL}, 1, 1'b0);
    check(motion.pos <= 384 && motion.pos > 370, 1'b1, "stop at index");
    run_case("m34", 8'h22, 400, {FL}, 1, 1'b0);
    check(motion.pos >= 448 && motion.pos < 462, 1'b1, "stop at index");
  endtask : test_index

  task automatic test_bad_write;
    write_obj(16'h6099, 8'h00, 8'h1b);
    cycles(2);
    check(method_code, 8'h22, "other index");
    write_obj(16'h6098, 8'h01, 8'h1b);
    cycles(2);
    check(method_code, 8'h22, "other subindex");
    $display("test bad write done");
  endtask : test_bad_write

  task automatic test_reserved;
    logic [7:0] codes [3] = '{8'h1f, 8'h20, 8'h05};
    foreach (codes[i])
    begin
      write_obj(16'h6098, 8'h00, codes[i]);
      cycles(6);
      pulse_start();
      cycles(6);
      check({method_error, run, homing_done}, 3'b100, "reserved code");
    end
    $display("test reserved done");
  endtask : test_reserved

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    check({run, stop_cmd, homing_done, method_error}, 4'b0100, "reset outputs");
    check(method_code, 8'h00, "reset code");
    cycles(4);
    test_m27();
    test_m28();
    test_m29();
    test_m30();
    test_index();
    test_bad_write();
    test_reserved();
    test_m27();
    stop_test();
  end
endmodule : tb_top
